// ### hw/exc_entry.sv
`include "exc_entry_cfg.svh"
`default_nettype none
module exc_entry
    import exc_entry_pkg::*;
(
    input  wire logic  sys_clk,         // Core clock, 100 MHz
    input  wire logic  rst_n,           // Async reset, active low
    input  wire logic  tb_tick_pin,     // Shared time base pin
    input  wire logic  higher_exc,      // Outranking exception pending
    input  wire logic  instr_valid,     // Instruction at instr_addr issues
    input  wire word_t instr_addr,      // Its effective address
    input  wire word_t next_addr,       // Address it would run next
    input  wire logic  float_instr,     // It is a float op (incl. ld/st)
    input  wire logic  iac_match,       // Instruction address compare
    input  wire logic  btac_match,      // Branch target compare
    input  wire word_t impl_ctrl,       // implementation_control_one
    input  wire logic  call_valid,      // system_call_instruction seen
    input  wire word_t call_word,       // Its instruction word
    input  wire word_t call_next_addr,  // Address after it
    input  wire logic  inflight_empty,  // All older work completed
    input  wire logic  io_err_valid,    // Interface error reply packet
    input  wire word_t io_err_addr,     // Address of the failing access
    input  wire word_t io_err_next_addr, // Instruction after it
    input  wire logic  io_illegal,      // Illegal interface-space access
    input  wire logic  io_misaligned,   // That access was misaligned
    input  wire logic  msw_wr,          // Software load of the state word
    input  wire word_t msw_wdata,       // Value loaded
    input  wire logic  dec_wr,          // Software store to decrementer
    input  wire word_t dec_wdata,       // Value stored
    output word_t      dec_count,       // Decrementer value
    output word_t      rtc_count,       // Real-time counter value
    output word_t      machine_state_word,   // Current state word
    output word_t      saved_return_address, // Return address
    output word_t      saved_machine_state,  // Saved state word
    output word_t      data_fault_address,   // Faulting data address
    output word_t      fetch_addr,      // Redirect target
    output logic       fetch_redirect,  // Pulse: fetch from fetch_addr
    output exc_vec_t   exc_taken,       // Pulse: which exception
    output logic       dispatch_halt,   // Stop issuing new instructions
    output logic       align_fault,     // Pulse: to alignment exception
    output logic       data_access_fault // Pulse: to data access exception
);
    dec_link dl ();

    seq_state_e state;
    exc_vec_t   req;
    exc_vec_t   grant;
    word_t      msw;
    word_t      call_ret;
    word_t      call_instr;
    word_t      base;
    word_t      vector;
    logic       run_enabled;
    logic       sync_hold;

    assign machine_state_word = msw;

    time_base u_time_base (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .tb_tick_pin (tb_tick_pin),
        .dec_wr      (dec_wr),
        .dec_wdata   (dec_wdata),
        .dec_count   (dec_count),
        .rtc_count   (rtc_count),
        .dl          (dl.tb)
    );

    // Run mode gate: bit 8 clear and bit 9 set
    assign run_enabled =
        impl_ctrl[`RUN_EN_HI:`RUN_EN_LO] == `RUN_EN_PATTERN;
    assign sync_hold = state == ST_SYNC;

    // Raw requests; while syncing only older work and the call itself
    always_comb begin
        req = '0;
        req[`EXC_IOERR] = io_err_valid & ~io_illegal;
        req[`EXC_FPU]   = ~sync_hold & instr_valid & float_instr
                          & ~msw[`MSW_FLOAT];
        req[`EXC_RUN]   = ~sync_hold & instr_valid & run_enabled
                          & (iac_match | btac_match
                             | msw[`MSW_STEP]);
        req[`EXC_CALL]  = sync_hold & inflight_empty;
        req[`EXC_DEC]   = ~sync_hold & dl.pending
                          & msw[`MSW_EXT_INT];
    end

    exc_priority #(
        .N (`EXC_COUNT)
    ) u_priority (
        .req   (req),
        .block (higher_exc),
        .grant (grant)
    );
    // Taking the decrementer clears its request
    assign dl.take = grant[`EXC_DEC];

    // Halt issue from the call onward; combinational so no slot leaks
    assign dispatch_halt = sync_hold | call_valid;

    // Call sequencing: hold the call until older work has settled
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_RUN;
            call_ret   <= '0;
            call_instr <= '0;
        end else begin
            unique case (state)
                ST_RUN: begin
                    if (call_valid && grant == '0) begin
                        state      <= ST_SYNC;
                        call_ret   <= call_next_addr;
                        call_instr <= call_word;
                    end
                end
                ST_SYNC: begin
                    // An older interface error flushes the call
                    if (grant[`EXC_CALL] || grant[`EXC_IOERR]) begin
                        state <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // Vector of the winner
    always_comb begin
        vector = '0;
        if (grant[`EXC_IOERR]) begin
            vector = `VEC_IO_ERROR;
        end else if (grant[`EXC_FPU]) begin
            vector = `VEC_FPU_UNAVAIL;
        end else if (grant[`EXC_RUN]) begin
            vector = `VEC_RUN_MODE;
        end else if (grant[`EXC_CALL]) begin
            vector = `VEC_SYS_CALL;
        end else if (grant[`EXC_DEC]) begin
            vector = `VEC_DECREMENTER;
        end
    end
    // Prefix is not changed by entry, so the old value picks the base
    assign base = msw[`MSW_PREFIX] ? `BASE_PREFIX_HI : `BASE_PREFIX_LO;

    // Redirect and cause pulses
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_addr     <= '0;
            fetch_redirect <= 1'b0;
            exc_taken      <= '0;
        end else begin
            fetch_redirect <= |grant;
            exc_taken      <= grant;
            if (|grant) begin
                fetch_addr <= base | vector;
            end
        end
    end

    // State word: entry clears the listed bits, ME and EP survive
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            msw <= `MSW_RESET;
        end else if (|grant) begin
            msw <= msw & ~`MSW_CLEAR_MASK;
        end else if (msw_wr) begin
            msw <= msw_wdata;
        end
    end

    // Return address per cause
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            saved_return_address <= '0;
        end else if (grant[`EXC_IOERR]) begin
            saved_return_address <= io_err_next_addr;
        end else if (grant[`EXC_FPU]) begin
            saved_return_address <= instr_addr;
        end else if (grant[`EXC_RUN]) begin
            saved_return_address <= instr_addr;
        end else if (grant[`EXC_CALL]) begin
            saved_return_address <= call_ret;
        end else if (grant[`EXC_DEC]) begin
            saved_return_address <= next_addr;
        end
    end

    // Saved state word per cause
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            saved_machine_state <= '0;
        end else if (grant[`EXC_RUN]) begin
            saved_machine_state <= msw;
        end else if (grant[`EXC_CALL]) begin
            // Low instruction half fills the high saved half
            saved_machine_state <= {call_instr[15:0], msw[15:0]};
        end else if (|grant) begin
            saved_machine_state <= {16'h0000, msw[15:0]};
        end
    end

    // Faulting data address, only for interface errors
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_fault_address <= '0;
        end else if (grant[`EXC_IOERR]) begin
            data_fault_address <= io_err_addr;
        end
    end

    // Illegal interface-space accesses leave through other exceptions
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            align_fault       <= 1'b0;
            data_access_fault <= 1'b0;
        end else begin
            align_fault       <= io_illegal & io_misaligned;
            data_access_fault <= io_illegal & ~io_misaligned;
        end
    end

    AST_FPU_TAKE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (instr_valid && float_instr && !msw[`MSW_FLOAT] && !higher_exc
         && !io_err_valid && state == ST_RUN)
        |=> exc_taken[`EXC_FPU]
            && fetch_addr[15:0] == 16'h0800)
        else $error("float-unavailable not taken");
    AST_MSW_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fetch_redirect |-> (msw & `MSW_CLEAR_MASK) == 32'h0
        && msw[`MSW_MCHECK] == $past(msw[`MSW_MCHECK])
        && msw[`MSW_PREFIX] == $past(msw[`MSW_PREFIX]))
        else $error("state word not set on entry");
    AST_SAVE_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (exc_taken[`EXC_FPU] || exc_taken[`EXC_DEC]
         || exc_taken[`EXC_IOERR])
        |-> saved_machine_state
            == {16'h0000, $past(msw[15:0])})
        else $error("saved state wrong");
    AST_FPU_RET: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exc_taken[`EXC_FPU]
        |-> saved_return_address == $past(instr_addr))
        else $error("float return address wrong");
    AST_VECTOR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exc_taken[`EXC_DEC] |-> fetch_addr == (($past(msw[`MSW_PREFIX]))
        ? `BASE_PREFIX_HI : `BASE_PREFIX_LO) + `VEC_DECREMENTER)
        else $error("decrementer fetch address wrong");
    AST_DEC_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exc_taken[`EXC_DEC] |-> $past(msw[`MSW_EXT_INT])
        && $past(dl.pending) && !$past(higher_exc))
        else $error("decrementer taken while masked");
    AST_DEC_CANCEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (exc_taken[`EXC_DEC] && !(!$past(dec_count[`DEC_MSB])
         && dec_count[`DEC_MSB])) |-> !dl.pending)
        else $error("request survived its exception");
    AST_DEC_RET: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exc_taken[`EXC_DEC]
        |-> saved_return_address == $past(next_addr))
        else $error("decrementer return address wrong");
    AST_IOERR_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exc_taken[`EXC_IOERR] |-> $past(io_err_valid)
        && !$past(io_illegal))
        else $error("interface error without reply");
    AST_IOERR_SAVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exc_taken[`EXC_IOERR]
        |-> saved_return_address == $past(io_err_next_addr)
            && data_fault_address == $past(io_err_addr))
        else $error("interface error addresses wrong");
    AST_ILLEGAL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        io_illegal |=> (align_fault ^ data_access_fault)
        && !exc_taken[`EXC_IOERR])
        else $error("illegal access misrouted");
    AST_CALL_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == ST_SYNC && !inflight_empty)
        |-> dispatch_halt ##1 !exc_taken[`EXC_CALL])
        else $error("call taken before work settled");
    AST_CALL_SAVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exc_taken[`EXC_CALL] |-> saved_return_address == $past(call_ret)
        && saved_machine_state[15:0] == $past(msw[15:0]))
        else $error("call save wrong");
    AST_RUN_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exc_taken[`EXC_RUN]
        |-> $past(impl_ctrl[`RUN_EN_HI:`RUN_EN_LO]) == 2'b01)
        else $error("run mode taken while disabled");
    AST_RUN_SAVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exc_taken[`EXC_RUN] |-> saved_machine_state == $past(msw)
        && saved_return_address == $past(instr_addr))
        else $error("run mode save wrong");
    AST_ONE_WINNER: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $onehot0(exc_taken) && (fetch_redirect == |exc_taken))
        else $error("more than one exception taken");

    COV_DEC: cover property (@(posedge sys_clk) disable iff (!rst_n)
        exc_taken[`EXC_DEC]);
    COV_CALL_WAIT: cover property (@(posedge sys_clk) disable iff (!rst_n)
        state == ST_SYNC ##1 state == ST_SYNC ##1 exc_taken[`EXC_CALL]);
    COV_IOERR: cover property (@(posedge sys_clk) disable iff (!rst_n)
        exc_taken[`EXC_IOERR]);
    COV_RUN: cover property (@(posedge sys_clk) disable iff (!rst_n)
        exc_taken[`EXC_RUN]);
endmodule
`default_nettype wire

// ### hw/exc_entry_cfg.svh
`ifndef EXC_ENTRY_CFG_SVH
`define EXC_ENTRY_CFG_SVH

// Vector offsets added to the prefix base
`define VEC_FPU_UNAVAIL 32'h0000_0800
`define VEC_DECREMENTER 32'h0000_0900
`define VEC_IO_ERROR    32'h0000_0a00
`define VEC_SYS_CALL    32'h0000_0c00
`define VEC_RUN_MODE    32'h0000_2000

// Physical bases chosen by exception_prefix
`define BASE_PREFIX_LO  32'h0000_0000
`define BASE_PREFIX_HI  32'hfff0_0000

// machine_state_word fields; big-endian bit n sits at index 31-n
`define MSW_EXT_INT  15
`define MSW_PROBLEM  14
`define MSW_FLOAT    13
`define MSW_MCHECK   12
`define MSW_FMODE_LO 11
`define MSW_STEP     10
`define MSW_FMODE_HI 8
`define MSW_PREFIX   6
`define MSW_ITRANS   5
`define MSW_DTRANS   4
`define MSW_CLEAR_MASK 32'h0000_ed30
`define MSW_RESET      32'h0000_0040

// Run mode enable field of implementation_control_one (bits 8 and 9)
`define RUN_EN_HI      23
`define RUN_EN_LO      22
`define RUN_EN_PATTERN 2'b01

// Exception index, lowest index wins
`define EXC_IOERR 0
`define EXC_FPU   1
`define EXC_RUN   2
`define EXC_CALL  3
`define EXC_DEC   4
`define EXC_COUNT 5

// Time base
`define DEC_RESET 32'h0000_0000
`define RTC_RESET 32'h0000_0000
`define DEC_MSB   31

`endif

// ### hw/exc_entry_pkg.sv
`include "exc_entry_cfg.svh"
`default_nettype none
package exc_entry_pkg;
    typedef logic [31:0] word_t;
    typedef logic [`EXC_COUNT-1:0] exc_vec_t;
    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_SYNC = 2'b10
    } seq_state_e;
endpackage
`default_nettype wire

// ### hw/dec_link.sv
`default_nettype none
interface dec_link;
    logic pending;    // Decrementer request waiting
    logic take;       // Decrementer exception taken this cycle
    modport tb   (output pending, input take);
    modport core (input pending, output take);
endinterface
`default_nettype wire

// ### hw/exc_priority.sv
`include "exc_entry_cfg.svh"
`default_nettype none
module exc_priority
    import exc_entry_pkg::*;
#(
    parameter int N = `EXC_COUNT
) (
    input  wire logic [N-1:0] req,    // Raw requests
    input  wire logic         block,  // Older exception outranks all
    output logic      [N-1:0] grant   // One-hot winner
);
    // Fixed order: lowest index first
    for (genvar i = 0; i < N; i++) begin : g_pri
        if (i == 0) begin : g_first
            assign grant[i] = req[i] & ~block;
        end else begin : g_rest
            assign grant[i] = req[i] & ~block & ~(|req[i-1:0]);
        end
    end
endmodule
`default_nettype wire

// ### hw/time_base.sv
`include "exc_entry_cfg.svh"
`default_nettype none
module time_base
    import exc_entry_pkg::*;
(
    input  wire logic  sys_clk,      // Core clock
    input  wire logic  rst_n,        // Async reset, active low
    input  wire logic  tb_tick_pin,  // Shared time base, from a pin
    input  wire logic  dec_wr,       // Software store to decrementer
    input  wire word_t dec_wdata,    // Value stored
    output word_t      dec_count,    // Decrementer, reads are passive
    output word_t      rtc_count,    // Real-time counter
    dec_link.tb        dl            // Request toward the core
);
    logic  tick_s1;
    logic  tick_s2;
    logic  tick_s3;
    logic  tick;
    logic  rise;
    logic  pending;
    word_t next_dec;

    // Pin synchroniser, then rising edge of the time base
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_s1 <= 1'b0;
            tick_s2 <= 1'b0;
            tick_s3 <= 1'b0;
        end else begin
            tick_s1 <= tb_tick_pin;
            tick_s2 <= tick_s1;
            tick_s3 <= tick_s2;
        end
    end
    assign tick = tick_s2 & ~tick_s3;

    // Write replaces the count outright, beating a same-cycle tick
    always_comb begin
        next_dec = dec_count;
        if (dec_wr) begin
            next_dec = dec_wdata;
        end else if (tick) begin
            next_dec = dec_count - 32'h0000_0001;
        end
    end
    // Top bit going 0 to 1, by counting or by a write
    assign rise = ~dec_count[`DEC_MSB] & next_dec[`DEC_MSB];

    // Both counters step on the same tick so they never drift
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_count <= `DEC_RESET;
            rtc_count <= `RTC_RESET;
        end else begin
            dec_count <= next_dec;
            if (tick) begin
                rtc_count <= rtc_count + 32'h0000_0001;
            end
        end
    end

    // One sticky request; a new rise beats a same-cycle take
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= 1'b0;
        end else if (rise) begin
            pending <= 1'b1;
        end else if (dl.take) begin
            pending <= 1'b0;
        end
    end
    assign dl.pending = pending;

    AST_DEC_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dec_wr |=> dec_count == $past(dec_wdata))
        else $error("decrementer write not taken");
    AST_DEC_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!dec_count[`DEC_MSB] ##1 dec_count[`DEC_MSB]) |-> pending)
        else $error("top bit rise did not raise request");
    AST_COHERENT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && !dec_wr) |=> (rtc_count == $past(rtc_count) + 32'h1 &&
        dec_count == $past(dec_count) - 32'h1))
        else $error("counters stepped apart");
endmodule
`default_nettype wire

// ### bench/pipe_partner.sv
`default_nettype none
// Bus reply packets and the drain of older pipeline work
module pipe_partner (
    input  wire logic       sys_clk, // Core clock
    input  wire logic       rst_n,   // Reset, active low
    input  wire logic       halt,    // Dispatch halted
    input  wire logic [3:0] drain,   // Cycles older work needs
    input  wire logic       fail,    // Access failed on the bus
    output logic            err_pkt, // Error reply packet
    output logic            empty    // Older work completed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] left;
    // Work drains only once halted, so a slow drain holds sync open
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            left <= 4'h0;
        else if (!halt)
            left <= drain;
        else if (left != 4'h0)
            left <= left - 4'h1;
    end
    assign empty = halt && (left == 4'h0);
    // Failure answers with one reply packet, a cycle late
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            err_pkt <= 1'b0;
        else
            err_pkt <= fail;
    end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`include "exc_entry_cfg.svh"
`default_nettype none
module tb_top
    import exc_entry_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst_n, tick, hx, iv, fi, iac, btac, call, ill, mis;
    logic mw, dw, fail, fr, halt, af, daf, pkt, emp;
    logic [3:0] drain;
    word_t ia, nea, ic, scw, md, dd, dec, rtc, msw, ra, ms, dfa, fa;
    exc_vec_t tk;
    int err_count, checked, cycles;
    exc_entry dut (.sys_clk(sys_clk), .rst_n(rst_n), .tb_tick_pin(tick),
        .higher_exc(hx), .instr_valid(iv), .instr_addr(ia),
        .next_addr(nea), .float_instr(fi), .iac_match(iac),
        .btac_match(btac), .impl_ctrl(ic), .call_valid(call),
        .call_word(scw), .call_next_addr(nea),
        .inflight_empty(emp), .io_err_valid(pkt), .io_err_addr(ia),
        .io_err_next_addr(nea), .io_illegal(ill), .io_misaligned(mis),
        .msw_wr(mw), .msw_wdata(md), .dec_wr(dw), .dec_wdata(dd),
        .dec_count(dec), .rtc_count(rtc), .machine_state_word(msw),
        .saved_return_address(ra), .saved_machine_state(ms),
        .data_fault_address(dfa), .fetch_addr(fa), .fetch_redirect(fr),
        .exc_taken(tk), .dispatch_halt(halt), .align_fault(af),
        .data_access_fault(daf));
    pipe_partner pm (.sys_clk(sys_clk), .rst_n(rst_n), .halt(halt),
        .drain(drain), .fail(fail), .err_pkt(pkt), .empty(emp));
    // Core clock, 100 MHz
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic nx();
        @(posedge sys_clk);
    endtask
    task automatic chk(input word_t got, input word_t exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask
    // Software load of the state word; returns at the edge it lands
    task automatic set_msw(input word_t v);
        nx();
        mw <= 1'b1;
        md <= v;
        nx();
        mw <= 1'b0;
    endtask
    // Entry results: pulses, target, saved pair, new state word
    task automatic see(input int i, input word_t v, r, s, n);
        #1;
        chk(word_t'({fr, tk}), 32'h20 | (32'h1 << i));
        chk(fa, (n[`MSW_PREFIX] ? `BASE_PREFIX_HI : `BASE_PREFIX_LO) | v);
        chk(ra, r);
        chk(ms, s);
        chk(msw, n);
    endtask
    task automatic t_float();
        set_msw(32'h1234_9040);
        {iv, fi} <= 2'b11;
        ia <= 32'h0000_1000;
        nx();
        {iv, fi} <= 2'b00;
        see(`EXC_FPU, `VEC_FPU_UNAVAIL, ia, 32'h9040,
            32'h1234_1040);
        $display("float test done");
    endtask
    // Interface error beats a float request of the same cycle
    task automatic t_io();
        set_msw(32'h0000_8040);
        fail <= 1'b1;
        ia <= 32'h8000_0010;
        nea <= 32'h0000_2004;
        nx();
        fail <= 1'b0;
        {iv, fi} <= 2'b11;
        nx();
        {iv, fi} <= 2'b00;
        see(`EXC_IOERR, `VEC_IO_ERROR, nea, 32'h8040,
            32'h0040);
        chk(dfa, ia);
        $display("io error test done");
    endtask
    // Error packet arrives with the illegal flag: no interface error
    task automatic t_ill();
        for (int m = 0; m < 2; m++) begin
            nx();
            fail <= 1'b1;
            nx();
            fail <= 1'b0;
            {ill, mis} <= {1'b1, m[0]};
            nx();
            ill <= 1'b0;
            #1 chk(word_t'({af, daf, tk}), {m[0], !m[0], 5'h0});
        end
        $display("illegal access test done");
    endtask
    task automatic t_call(input int d);
        int n;
        nx();
        drain <= d[3:0];
        scw <= 32'h0000_abcd;
        nea <= 32'h0000_3004;
        set_msw(32'h0000_9040);
        call <= 1'b1;
        nx();
        call <= 1'b0;
        for (n = 0; n < 20; n++) begin
            #1;
            if (tk[`EXC_CALL] === 1'b1)
                break;
            chk(word_t'(halt), 32'h1);
            nx();
        end
        chk(word_t'(n), word_t'((d > 1) ? d : 1));
        see(`EXC_CALL, `VEC_SYS_CALL, nea, 32'habcd_9040,
            32'h0000_1040);
        $display("system call test done");
    endtask
    // Wrong enable pattern, then an outranking block, then taken
    task automatic t_run();
        word_t v;
        for (int k = 0; k < 3; k++) begin
            v = (k == 2) ? 32'h5a5a_9440 : 32'h5a5a_9040;
            set_msw(v);
            {iv, iac, btac} <= {1'b1, k == 0, k == 1};
            ia <= 32'h0000_4000 + k;
            ic <= 32'h0080_0000;
            nx();
            ic <= 32'h0040_0000;
            hx <= 1'b1;
            #1 chk(word_t'(tk), 32'h0);
            nx();
            hx <= 1'b0;
            #1 chk(word_t'(tk), 32'h0);
            nx();
            {iv, iac, btac} <= 3'b000;
            see(`EXC_RUN, `VEC_RUN_MODE, ia, v,
                32'h5a5a_1040);
        end
        $display("run mode test done");
    endtask
    task automatic t_dec();
        word_t r0;
        set_msw(32'h0000_8040);
        {dw, dd, nea} <= {1'b1, 32'h8000_0000, 32'h0000_5008};
        nx();
        dw <= 1'b0;
        #1 chk(dec, 32'h8000_0000);
        nx();
        see(`EXC_DEC, `VEC_DECREMENTER, nea, 32'h8040,
            32'h0040);
        nx();
        {dw, dd} <= {1'b1, 32'h0000_0002};
        nx();
        dw <= 1'b0;
        r0 = rtc;
        repeat (6) begin
            tick <= !tick;
            repeat (4) nx();
        end
        chk(dec, 32'hffff_ffff);
        chk(rtc, r0 + 32'h3);
        {dw, dd} <= 33'h0;
        nx();
        {dw, dd} <= {1'b1, 32'h8000_0000};
        nx();
        dw <= 1'b0;
        #1 chk(word_t'(tk), 32'h0);
        set_msw(32'h0000_8040);
        nx();
        see(`EXC_DEC, `VEC_DECREMENTER, nea, 32'h8040, 32'h0040);
        nx();
        #1 chk(word_t'(tk), 32'h0);
        $display("decrementer test done");
    endtask
    task automatic summarize();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Hang guard, far above the hundred or so cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        {rst_n, tick, hx, iv, fi, iac, btac, call, ill, mis} = '0;
        {mw, dw, fail, drain, ia, nea, ic, scw, md, dd} = '0;
        {err_count, checked, cycles} = '0;
        repeat (4) nx();
        rst_n <= 1'b1;
        t_float();
        t_io();
        t_ill();
        t_call(0);
        t_call(5);
        t_run();
        t_dec();
        summarize();
    end
endmodule
`default_nettype wire
